// >>> pkg/csg_pkg.sv
// Purpose: shared constants for clock source generation control
// Assumes: one 25 MHz system clock, plain register port
// Notes: oscillators are modelled as enables and status inputs
package csg_pkg;
   localparam int CSG_AW = 4;
   localparam int CSG_DW = 8;
   // register offsets
   localparam logic [3:0] CSG_CLOCK_MODE_REG_ZERO = 4'h0;
   localparam logic [3:0] CSG_CLOCK_MODE_REG_ONE = 4'h1;
   localparam logic [3:0] CSG_CLOCK_MODE_REG_TWO = 4'h2;
   localparam logic [3:0] CSG_PLL_CONTROL_REG = 4'h3;
   localparam logic [3:0] CSG_PROCESSOR_MODE_REG_TWO = 4'h4;
   localparam logic [3:0] CSG_PORT_EIGHT_DIRECTION_REG = 4'h5;
   localparam logic [3:0] CSG_PULLUP_CONTROL_REG_TWO = 4'h6;
   localparam logic [3:0] CSG_STATUS_REG = 4'h7;
   // clock_mode_reg_zero fields
   localparam int CSG_B_WAIT_PERIPH_STOP = 2;
   localparam int CSG_B_SUB_OSC_EN = 4;
   localparam int CSG_B_MAIN_STOP = 5;
   localparam int CSG_B_CPU_SUB_SEL = 7;
   // clock_mode_reg_one
   localparam int CSG_B_PLL_CPU_SEL = 7;
   // clock_mode_reg_two
   localparam int CSG_B_DETECT_EN = 0;
   localparam int CSG_B_ONCHIP_SEL = 1;
   localparam int CSG_B_DETECTED = 2;
   localparam int CSG_B_MAIN_HALTED = 3;
   // pll_control_reg
   localparam int CSG_B_PLL_RUN = 7;
   localparam int CSG_F_PREDIV_LO = 4;
   localparam int CSG_F_MUL_LO = 0;
   // processor_mode_reg_two
   localparam int CSG_B_WDT_SRC = 2;
   localparam int CSG_F_PRESC_LO = 6;
   // port / pullup bits
   localparam int CSG_B_SUB_OUT_DIR = 7;
   localparam int CSG_B_SUB_IN_DIR = 6;
   localparam int CSG_B_SUB_PULLUP = 5;
   localparam logic [1:0] CSG_PRESC_ONCHIP = 2'b10;
   localparam logic [1:0] CSG_PREDIV_2 = 2'b01;
   localparam logic [1:0] CSG_PREDIV_4 = 2'b10;
   localparam logic [2:0] CSG_MUL_8 = 3'b100;
   // reset values
   localparam logic [7:0] CSG_PLL_RESET = 8'h14;
   localparam logic [7:0] CSG_ZERO_BYTE = 8'h00;
   // cpu divider after reset is divide by eight
   localparam logic [4:0] CSG_CPU_DIV_RESET = 5'h08;
   // timing
   localparam int CSG_CLK_HZ = 25000000;
   localparam int CSG_PLL_SETTLE_US = 20;
   localparam int CSG_PLL_SETTLE_CYC =
      (CSG_PLL_SETTLE_US * (CSG_CLK_HZ / 1000000));
   localparam int CSG_LOSS_NS = 2000;
   localparam int CSG_LOSS_CYC = (CSG_LOSS_NS * 25 + 999) / 1000;
   // clock source codes
   typedef enum logic [1:0] {CSG_SRC_MAIN, CSG_SRC_SUB, CSG_SRC_ONCHIP,
      CSG_SRC_PLL} csg_src_e;
endpackage : csg_pkg

// >>> design/csg_edge_watch.sv
// Purpose: watches a sampled clock level for lack of edges
// Assumes: input already synchronised to clk
// Notes: lost asserts on the LIMIT+1th consecutive cycle with no toggle
`timescale 1ns/1ps
`default_nettype none
module csg_edge_watch #(
   parameter int LIMIT = 50
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic level,
   output logic lost
);
   typedef struct packed {
      logic prev;
      logic [15:0] cnt;
      logic lost;
   } csg_watch_s;
   csg_watch_s q, next_q;
   always_comb
   begin
      next_q = q;
      next_q.prev = level;
      if (!enable || level != q.prev)
      begin
         next_q.cnt = 16'h0000;
         next_q.lost = 1'b0;
      end
      else if (q.cnt >= 16'(LIMIT))
         next_q.lost = 1'b1;
      else
         next_q.cnt = q.cnt + 16'h0001;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= next_q;
   end
   assign lost = q.lost;
endmodule : csg_edge_watch
`default_nettype wire

// >>> design/csg_settle_timer.sv
// Purpose: counts a settling time after an enable rises
// Assumes: enable is a level from a register
// Notes: ready drops at the next clock edge after enable drops
`timescale 1ns/1ps
`default_nettype none
module csg_settle_timer #(
   parameter int CYCLES = 500
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   output logic ready
);
   typedef struct packed {
      logic [15:0] cnt;
      logic ready;
   } csg_settle_s;
   csg_settle_s q, next_q;
   always_comb
   begin
      next_q = q;
      if (!enable)
         next_q = '0;
      else if (q.cnt >= 16'(CYCLES - 1))
         next_q.ready = 1'b1;
      else
         next_q.cnt = q.cnt + 16'h0001;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= next_q;
   end
   assign ready = q.ready;
endmodule : csg_settle_timer
`default_nettype wire

// >>> design/csg_clock_source.sv
// Purpose: clock source control: oscillator enables, selection, stop detect
// Assumes: oscillator levels sampled synchronously to clk
// Notes: source selects change on a select_sync handshake, or at once on main clock loss
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - reset: cpu source main divided eight
// - stop mode: disconnect both feedback resistors
// - main stop: halt, out high, resistor on
// - stop mode stops every clock source
// - reset: sub off, resistor disconnected
// - external sub clock taken from sub input
// - sub select after stabilization uses sub
// - on-chip 1 MHz, stopped after reset
// - on-chip select starts it, replaces main
// - watchdog or prescaled select starts on-chip
// - main loss: interrupt, on-chip, set flags
// - shared vector; handler checks detected flag
// - low-speed loss: sub stays cpu source
// - detection off while peripheral clocks stopped
// - pll: main over prediv times multiply
// - pll off at reset, settles after run
// - peripheral source from pll and on-chip selects
module csg_clock_source
   import csg_pkg::*;
#(
   parameter int PLL_SETTLE_CYC = CSG_PLL_SETTLE_CYC,
   parameter int LOSS_CYC = CSG_LOSS_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic main_osc_level,
   input wire logic sub_osc_in,
   input wire logic select_sync,
   output logic main_osc_enable,
   output logic main_osc_out,
   output logic main_feedback_on,
   output logic sub_osc_enable,
   output logic sub_feedback_on,
   output logic sub_external_clock,
   output logic onchip_osc_enable,
   output logic pll_enable,
   output logic [1:0] pll_prediv,
   output logic [2:0] pll_multiply,
   output logic pll_locked,
   output logic [1:0] cpu_source,
   output logic [1:0] periph_source,
   output logic [4:0] cpu_divider,
   output logic sub_out_drive_n,
   output logic osc_stop_irq
);
   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic [7:0] mode0;
      logic [7:0] mode1;
      logic [7:0] mode2;
      logic [7:0] pllc;
      logic [7:0] pmode2;
      logic [7:0] pdir8;
      logic [7:0] pullup_control_reg_two;
      logic [7:0] rdata;
      logic [1:0] cpu_src;
      logic [1:0] per_src;
      logic irq;
   } csg_state_s;
   csg_state_s q, next_q;
   logic main_lost;
   logic pll_ready;
   logic detect_live;
   logic [1:0] want_cpu;
   logic [1:0] want_per;
   // ***********************************************************
   // helpers
   // ***********************************************************
   // peripheral clocks stop in wait mode when asked; detection then blind
   always_comb
   begin
      detect_live = q.mode2[CSG_B_DETECT_EN] && !stop_mode
         && !q.mode0[CSG_B_MAIN_STOP]
         && !(wait_mode && q.mode0[CSG_B_WAIT_PERIPH_STOP]);
   end
   csg_edge_watch #(
      .LIMIT(LOSS_CYC)
   ) u_watch (
      .clk(clk),
      .rst_n(rst_n),
      .enable(detect_live),
      .level(main_osc_level),
      .lost(main_lost)
   );
   csg_settle_timer #(
      .CYCLES(PLL_SETTLE_CYC)
   ) u_settle (
      .clk(clk),
      .rst_n(rst_n),
      .enable(pll_enable),
      .ready(pll_ready)
   );
   // ***********************************************************
   // source choice
   // ***********************************************************
   always_comb
   begin
      if (q.mode2[CSG_B_ONCHIP_SEL])
         want_per = CSG_SRC_ONCHIP;
      else if (q.mode1[CSG_B_PLL_CPU_SEL] && pll_ready)
         want_per = CSG_SRC_PLL;
      else
         want_per = CSG_SRC_MAIN;
      // sub keeps cpu in low speed
      if (q.mode0[CSG_B_CPU_SUB_SEL])
         want_cpu = CSG_SRC_SUB;
      else
         want_cpu = want_per;
   end
   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb
   begin
      next_q = q;
      next_q.rdata = CSG_ZERO_BYTE;
      if (reg_write)
      begin
         case (reg_addr)
            CSG_CLOCK_MODE_REG_ZERO: next_q.mode0 = reg_wdata;
            CSG_CLOCK_MODE_REG_ONE: next_q.mode1 = reg_wdata;
            CSG_CLOCK_MODE_REG_TWO:
            begin
               next_q.mode2[CSG_B_DETECT_EN] = reg_wdata[CSG_B_DETECT_EN];
               next_q.mode2[CSG_B_ONCHIP_SEL] =
                  reg_wdata[CSG_B_ONCHIP_SEL];
               // flags clear by writing zero only
               if (!reg_wdata[CSG_B_DETECTED])
                  next_q.mode2[CSG_B_DETECTED] = 1'b0;
               if (!reg_wdata[CSG_B_MAIN_HALTED])
                  next_q.mode2[CSG_B_MAIN_HALTED] = 1'b0;
            end
            CSG_PLL_CONTROL_REG: next_q.pllc = reg_wdata;
            CSG_PROCESSOR_MODE_REG_TWO: next_q.pmode2 = reg_wdata;
            CSG_PORT_EIGHT_DIRECTION_REG: next_q.pdir8 = reg_wdata;
            CSG_PULLUP_CONTROL_REG_TWO: next_q.pullup_control_reg_two = reg_wdata;
            default: next_q.mode0 = q.mode0;
         endcase
      end
      if (main_lost && detect_live)
      begin
         next_q.mode2[CSG_B_ONCHIP_SEL] = 1'b1;
         next_q.mode2[CSG_B_DETECTED] = 1'b1;
         next_q.mode2[CSG_B_MAIN_HALTED] = 1'b1;
      end
      next_q.irq = main_lost && detect_live && !q.mode2[CSG_B_DETECTED];
      if (reg_read)
      begin
         case (reg_addr)
            CSG_CLOCK_MODE_REG_ZERO: next_q.rdata = q.mode0;
            CSG_CLOCK_MODE_REG_ONE: next_q.rdata = q.mode1;
            CSG_CLOCK_MODE_REG_TWO: next_q.rdata = q.mode2;
            CSG_PLL_CONTROL_REG: next_q.rdata = q.pllc;
            CSG_PROCESSOR_MODE_REG_TWO: next_q.rdata = q.pmode2;
            CSG_PORT_EIGHT_DIRECTION_REG: next_q.rdata = q.pdir8;
            CSG_PULLUP_CONTROL_REG_TWO: next_q.rdata = q.pullup_control_reg_two;
            CSG_STATUS_REG:
               next_q.rdata = {2'b00, q.per_src, q.cpu_src,
                  pll_ready, main_lost};
            default: next_q.rdata = CSG_ZERO_BYTE;
         endcase
      end
      if (select_sync)
      begin
         next_q.cpu_src = want_cpu;
         next_q.per_src = want_per;
      end
      if (main_lost && detect_live)
      begin
         next_q.per_src = CSG_SRC_ONCHIP;
         if (!q.mode0[CSG_B_CPU_SUB_SEL])
            next_q.cpu_src = CSG_SRC_ONCHIP;
      end
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.pllc <= CSG_PLL_RESET;
         q.cpu_src <= CSG_SRC_MAIN;
         q.per_src <= CSG_SRC_MAIN;
      end
      else
         q <= next_q;
   end
   // ***********************************************************
   // outputs
   // ***********************************************************
   always_comb
   begin
      // all sources stop in stop mode
      main_osc_enable = !stop_mode && !q.mode0[CSG_B_MAIN_STOP];
      main_osc_out = q.mode0[CSG_B_MAIN_STOP];
      main_feedback_on = !stop_mode;
      sub_osc_enable = !stop_mode && q.mode0[CSG_B_SUB_OSC_EN];
      sub_feedback_on = sub_osc_enable;
      sub_external_clock = q.mode0[CSG_B_SUB_OSC_EN]
         && q.pdir8[CSG_B_SUB_IN_DIR] && !q.pullup_control_reg_two[CSG_B_SUB_PULLUP];
      sub_out_drive_n = !(sub_osc_enable && !sub_external_clock);
      onchip_osc_enable = !stop_mode && (q.mode2[CSG_B_ONCHIP_SEL]
         || q.pmode2[CSG_B_WDT_SRC]
         || q.pmode2[CSG_F_PRESC_LO +: 2] == CSG_PRESC_ONCHIP);
      pll_enable = !stop_mode && q.pllc[CSG_B_PLL_RUN];
      pll_prediv = q.pllc[CSG_F_PREDIV_LO +: 2];
      pll_multiply = q.pllc[CSG_F_MUL_LO +: 3];
      pll_locked = pll_ready;
      cpu_source = q.cpu_src;
      periph_source = q.per_src;
      cpu_divider = CSG_CPU_DIV_RESET;
      reg_rdata = q.rdata;
      osc_stop_irq = q.irq;
   end
   // ***********************************************************
   // checks
   // ***********************************************************
   property p_loss_onchip;
      @(posedge clk) disable iff (!rst_n)
      (main_lost && detect_live) |=> (periph_source == CSG_SRC_ONCHIP);
   endproperty
   a_loss_onchip: assert property (p_loss_onchip)
      else $error("loss did not select on-chip source");
   property p_loss_flags;
      @(posedge clk) disable iff (!rst_n)
      (main_lost && detect_live) |=> (q.mode2[CSG_B_DETECTED]
         && q.mode2[CSG_B_MAIN_HALTED] && onchip_osc_enable | stop_mode);
   endproperty
   a_loss_flags: assert property (p_loss_flags)
      else $error("loss flags not set");
   property p_sub_kept;
      @(posedge clk) disable iff (!rst_n)
      (main_lost && detect_live && cpu_source == CSG_SRC_SUB
         && q.mode0[CSG_B_CPU_SUB_SEL]) |=> (cpu_source == CSG_SRC_SUB);
   endproperty
   a_sub_kept: assert property (p_sub_kept)
      else $error("sub source lost on main loss");
   property p_stop_all;
      @(posedge clk) disable iff (!rst_n)
      stop_mode |-> !main_osc_enable && !sub_osc_enable
         && !onchip_osc_enable && !pll_enable && !main_feedback_on;
   endproperty
   a_stop_all: assert property (p_stop_all)
      else $error("source running in stop mode");
   property p_main_halt;
      @(posedge clk) disable iff (!rst_n)
      (stop_mode == 1'b0 && q.mode0[CSG_B_MAIN_STOP]) |->
         main_osc_out && main_feedback_on && !main_osc_enable;
   endproperty
   a_main_halt: assert property (p_main_halt)
      else $error("main halt pin state wrong");
   property p_no_auto_return;
      @(posedge clk) disable iff (!rst_n)
      (q.mode2[CSG_B_ONCHIP_SEL] && !(reg_write
         && reg_addr == CSG_CLOCK_MODE_REG_TWO))
         |=> q.mode2[CSG_B_ONCHIP_SEL];
   endproperty
   a_no_auto_return: assert property (p_no_auto_return)
      else $error("on-chip select dropped on its own");
   property p_switch_sync;
      @(posedge clk) disable iff (!rst_n)
      (!select_sync && !(main_lost && detect_live)) |=> $stable(cpu_source);
   endproperty
   a_switch_sync: assert property (p_switch_sync)
      else $error("cpu source changed off sync");
   property p_pll_settle;
      @(posedge clk) disable iff (!rst_n)
      $rose(pll_enable) |-> !pll_locked [*2];
   endproperty
   a_pll_settle: assert property (p_pll_settle)
      else $error("pll ready without settling");
   property p_blind_wait;
      @(posedge clk) disable iff (!rst_n)
      (wait_mode && q.mode0[CSG_B_WAIT_PERIPH_STOP]) |=> !osc_stop_irq;
   endproperty
   a_blind_wait: assert property (p_blind_wait)
      else $error("detection live with peripheral clocks off");
   c_loss: cover property (@(posedge clk) disable iff (!rst_n)
      osc_stop_irq);
   c_pll: cover property (@(posedge clk) disable iff (!rst_n)
      cpu_source == CSG_SRC_PLL);
   c_sub: cover property (@(posedge clk) disable iff (!rst_n)
      cpu_source == CSG_SRC_SUB);
endmodule : csg_clock_source
`default_nettype wire

// >>> sim/csg_osc_model.sv
// Purpose: crystal side model, main and external sub oscillators
// Assumes: levels are handed to the block already synchronised
// Notes: fault freezes the main level, like a crystal that died
`timescale 1ns/1ps
`default_nettype none
module csg_osc_model #(
   parameter int MAIN_HALF = 2,
   parameter int SUB_HALF = 7
) (
   input wire logic clk,
   input wire logic main_run,
   input wire logic sub_run,
   input wire logic fault,
   output logic main_level,
   output logic sub_level
);
   int main_cnt = 0;
   int sub_cnt = 0;
   initial main_level = 1'b0;
   initial sub_level = 1'b0;
   // ************************
   // oscillation
   // ************************
   // a stopped circuit holds its last level, no edges at all
   always @(posedge clk)
   begin
      main_cnt <= (main_cnt + 1) % MAIN_HALF;
      sub_cnt <= (sub_cnt + 1) % SUB_HALF;
      if (main_run && !fault && main_cnt == 0)
         main_level <= !main_level;
      if (sub_run && sub_cnt == 0)
         sub_level <= !sub_level;
   end
endmodule : csg_osc_model
`default_nettype wire

// >>> sim/test_clock_source_generation.sv
// Purpose: self-checking bench for the clock source control block
// Assumes: short settle and loss counts, select_sync mostly high
// Notes: reset defaults first, then table rows, pll, loss, stop and mid-run reset cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("wrong value %s expected %0h seen %0h", nm, e, g); \
      end \
   end
module test_clock_source_generation;
   import csg_pkg::*;
   typedef struct {
      logic [3:0] addr;
      logic [7:0] data;
      logic [7:0] back;
      logic [6:0] exp;
   } csg_row_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic stop_mode = 1'b0;
   logic wait_mode = 1'b0;
   logic main_osc_level;
   logic sub_osc_in;
   logic select_sync = 1'b1;
   logic fault = 1'b0;
   logic main_osc_enable, main_osc_out, main_feedback_on, sub_osc_enable;
   logic sub_feedback_on, sub_external_clock, onchip_osc_enable;
   logic pll_enable, pll_locked, sub_out_drive_n, osc_stop_irq;
   logic [1:0] pll_prediv, cpu_source, periph_source;
   logic [2:0] pll_multiply;
   logic [4:0] cpu_divider;
   logic [6:0] outs;
   logic [7:0] got;
   logic [3:0] srcs;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   // enables, out level, resistors, on-chip and pll as one vector
   csg_row_s rows[6] = '{
      '{4'h0, 8'h10, 8'h00, 7'b1011100},
      '{4'h2, 8'h02, 8'h00, 7'b1010010},
      '{4'h4, 8'h04, 8'h00, 7'b1010010},
      '{4'h4, 8'h80, 8'h00, 7'b1010010},
      '{4'h4, 8'h40, 8'h00, 7'b1010000},
      '{4'h3, 8'h94, 8'h14, 7'b1010001}};
   assign outs = {main_osc_enable, main_osc_out, main_feedback_on,
      sub_osc_enable, sub_feedback_on, onchip_osc_enable, pll_enable};
   assign srcs = {cpu_source, periph_source};
   always #20 clk = !clk;
   csg_clock_source #(.PLL_SETTLE_CYC(4), .LOSS_CYC(5)) u_dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .stop_mode(stop_mode), .wait_mode(wait_mode),
      .main_osc_level(main_osc_level), .sub_osc_in(sub_osc_in),
      .select_sync(select_sync), .main_osc_enable(main_osc_enable),
      .main_osc_out(main_osc_out), .main_feedback_on(main_feedback_on),
      .sub_osc_enable(sub_osc_enable), .sub_feedback_on(sub_feedback_on),
      .sub_external_clock(sub_external_clock),
      .onchip_osc_enable(onchip_osc_enable), .pll_enable(pll_enable),
      .pll_prediv(pll_prediv), .pll_multiply(pll_multiply),
      .pll_locked(pll_locked), .cpu_source(cpu_source),
      .periph_source(periph_source), .cpu_divider(cpu_divider),
      .sub_out_drive_n(sub_out_drive_n), .osc_stop_irq(osc_stop_irq));
   csg_osc_model u_osc (
      .clk(clk), .main_run(main_osc_enable), .sub_run(sub_osc_enable),
      .fault(fault), .main_level(main_osc_level), .sub_level(sub_osc_in));
   // ************************
   // bus and check tasks
   // ************************
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      got = reg_rdata;
   endtask : rd
   task settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : settle
   // loss must show as one single-cycle request
   task wait_irq;
      int n;
      n = 0;
      while (osc_stop_irq !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      `CHK("irq", 1'b1, osc_stop_irq);
      @(negedge clk);
      `CHK("irq pulse", 1'b0, osc_stop_irq);
      settle();
   endtask : wait_irq
   task print_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   // ************************
   // main sequence
   // ************************
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK("cpu src", CSG_SRC_MAIN, cpu_source);
      `CHK("cpu div", CSG_CPU_DIV_RESET, cpu_divider);
      `CHK("outs", 7'b1010000, outs);
      `CHK("locked", 1'b0, pll_locked);
      `CHK("prediv", CSG_PREDIV_2, pll_prediv);
      `CHK("mul", CSG_MUL_8, pll_multiply);
      rd(CSG_PLL_CONTROL_REG);
      `CHK("pll reg", CSG_PLL_RESET, got);
      rd(4'h8);
      `CHK("unmapped", 8'h00, got);
      // software clears pins before enabling, defaults are clear
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].data);
         settle();
         `CHK("row outs", rows[i].exp, outs);
         wr(rows[i].addr, rows[i].back);
         settle();
      end
      wr(CSG_PLL_CONTROL_REG, 8'ha4);
      @(negedge clk);
      `CHK("prediv4", CSG_PREDIV_4, pll_prediv);
      `CHK("early lock", 1'b0, pll_locked);
      repeat (8) @(negedge clk);
      `CHK("locked", 1'b1, pll_locked);
      wr(CSG_CLOCK_MODE_REG_ONE, 8'h80);
      settle();
      `CHK("pll src", {CSG_SRC_PLL, CSG_SRC_PLL}, srcs);
      rd(CSG_STATUS_REG);
      `CHK("status", 8'h3e, got);
      wr(CSG_CLOCK_MODE_REG_ONE, 8'h00);
      wr(CSG_PLL_CONTROL_REG, CSG_PLL_RESET);
      settle();
      `CHK("unlock", 1'b0, pll_locked);
      // main stopped only once on-chip drives the cpu
      @(posedge clk);
      select_sync <= 1'b0;
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h02);
      settle();
      `CHK("held src", 4'h0, srcs);
      @(posedge clk);
      select_sync <= 1'b1;
      settle();
      `CHK("onchip src", {CSG_SRC_ONCHIP, CSG_SRC_ONCHIP}, srcs);
      wr(CSG_CLOCK_MODE_REG_ZERO, 8'h20);
      settle();
      `CHK("main stop", 3'b011, outs[6:4]);
      wr(CSG_CLOCK_MODE_REG_ZERO, 8'h00);
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h00);
      settle();
      `CHK("main src", CSG_SRC_MAIN, cpu_source);
      // model main clock above 2 MHz
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h01);
      settle();
      fault <= 1'b1;
      wait_irq();
      `CHK("loss src", {CSG_SRC_ONCHIP, CSG_SRC_ONCHIP}, srcs);
      rd(CSG_CLOCK_MODE_REG_TWO);
      `CHK("flags", 8'h0f, got);
      fault <= 1'b0;
      repeat (20) @(negedge clk);
      `CHK("no return", CSG_SRC_ONCHIP, cpu_source);
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h00);
      settle();
      rd(CSG_CLOCK_MODE_REG_TWO);
      `CHK("cleared", 8'h00, got);
      `CHK("reselect", CSG_SRC_MAIN, cpu_source);
      // peripheral clocks off in wait blind the detector
      wr(CSG_CLOCK_MODE_REG_ZERO, 8'h04);
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h01);
      @(posedge clk);
      wait_mode <= 1'b1;
      fault <= 1'b1;
      repeat (20) @(negedge clk);
      `CHK("blind irq", 1'b0, osc_stop_irq);
      rd(CSG_CLOCK_MODE_REG_TWO);
      `CHK("blind flags", 8'h01, got);
      fault <= 1'b0;
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h00);
      @(posedge clk);
      wait_mode <= 1'b0;
      wr(CSG_CLOCK_MODE_REG_ZERO, 8'h10);
      settle();
      wr(CSG_CLOCK_MODE_REG_ZERO, 8'h90);
      settle();
      `CHK("sub src", CSG_SRC_SUB, cpu_source);
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h01);
      settle();
      fault <= 1'b1;
      wait_irq();
      `CHK("low speed", {CSG_SRC_SUB, CSG_SRC_ONCHIP}, srcs);
      // detection off before stopping on purpose
      fault <= 1'b0;
      // let the watcher see edges again, else the set beats the clear
      repeat (8) @(negedge clk);
      wr(CSG_CLOCK_MODE_REG_TWO, 8'h00);
      wr(CSG_CLOCK_MODE_REG_ZERO, 8'h10);
      settle();
      `CHK("xtal sub", 2'b00, {sub_external_clock, sub_out_drive_n});
      wr(CSG_PORT_EIGHT_DIRECTION_REG, 8'h40);
      settle();
      `CHK("ext sub", 2'b11, {sub_external_clock, sub_out_drive_n});
      wr(CSG_PORT_EIGHT_DIRECTION_REG, 8'h00);
      wr(CSG_PROCESSOR_MODE_REG_TWO, 8'h04);
      settle();
      @(posedge clk);
      stop_mode <= 1'b1;
      settle();
      `CHK("stop mode", 7'b0000000, {outs[6], outs[4:0], 1'b0});
      @(posedge clk);
      stop_mode <= 1'b0;
      settle();
      // mid-run reset returns every source to its default
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK("reset outs", 7'b1010000, outs);
      `CHK("reset src", 4'h0, srcs);
      print_verdict();
   end
endmodule : test_clock_source_generation
`undef CHK
`default_nettype wire
